// ---- rtl/morf_pkg.sv ----
// Summary of operation
// - Address zero reaches register chosen by ram_pointer
// - Timer counts pin edges or instruction cycles
// - Prescaler feeds timer while prescaler_assign is zero
// - Only a timer write clears the prescaler
// - Program counter and stack entries are 10 bits
// - Reset forces program counter to zero
// - Jump loads full 10-bit target
// - Call loads target, pushes next address
// - All three returns reload from stack top
// - Add to counter sums, clears two top bits
// - Move to counter loads low byte, clears top
// - Any counter register write clears bits 8, 9
// - One instruction cycle, counter changes take two
// - Status holds carry, half carry, zero flags
// - Power-down flag set by reset/clear, cleared by sleep
// - Time-out flag set by sleep/clear/reset, watchdog clears
// - Status bits 5 to 7 are spare storage
// - Pointer uses six bits, top two read one
// - Pointer at 3F sets zero, increment wraps
// - Two port registers, first only four bits
// - Timer, port change, external edge set sticky flags
// - Flag register writes can only clear
// - Flag read returns flags AND mask
// - Byte registers 10 to 3F are general storage
// - Mask bits 0 to 2 enable three sources
// - Edge select zero rising, one falling
package morf_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 8;
    localparam int IDX_LSB = 2;
    localparam int PC_W = 10;
    localparam int PTR_W = 6;
    localparam int PORT_A_W = 4;
    localparam int IRQ_W = 3;
    localparam int GP_COUNT = 48;
    localparam int BUSY_W = 4;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_INDIRECT = 8'h00;
    localparam logic [IDX_W-1:0] IDX_TIMER = 8'h01;
    localparam logic [IDX_W-1:0] IDX_PC = 8'h02;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h03;
    localparam logic [IDX_W-1:0] IDX_RAMPTR = 8'h04;
    localparam logic [IDX_W-1:0] IDX_PORT_A = 8'h05;
    localparam logic [IDX_W-1:0] IDX_PORT_B = 8'h06;
    localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 8'h0F;
    localparam logic [IDX_W-1:0] IDX_GP_FIRST = 8'h10;
    localparam logic [IDX_W-1:0] IDX_GP_LAST = 8'h3F;
    localparam logic [IDX_W-1:0] IDX_CORE_CMD = 8'h40;
    localparam logic [IDX_W-1:0] IDX_TSETUP = 8'h41;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h42;
    localparam logic [IDX_W-1:0] IDX_CORE_STAT = 8'h43;

    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam logic [BYTE_W-1:0] ST_SW_MASK = 8'hE7;
    localparam logic [BYTE_W-1:0] ST_RST = 8'h18;

    // Interrupt flag and mask bit positions
    localparam int IRQ_TIMER = 0;
    localparam int IRQ_PORT = 1;
    localparam int IRQ_EXT = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    localparam logic [1:0] PTR_FIXED_ONES = 2'h3;
    localparam logic [PTR_W-1:0] PTR_TOP = 6'h3F;
    localparam logic [PC_W-1:0] PC_RST = 10'h000;
    localparam logic [BYTE_W-1:0] TIMER_MAX = 8'hFF;

    // Instruction cycle is two core clocks
    localparam logic [BUSY_W-1:0] ICYCLE_CLKS = 4'h2;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_JUMP = 4'h1,
        OP_CALL = 4'h2,
        OP_RET = 4'h3,
        OP_RETURN_WITH_LITERAL = 4'h4,
        OP_RETURN_FROM_INTERRUPT = 4'h5,
        OP_ADD_PC = 4'h6,
        OP_MOV_PC = 4'h7,
        OP_SLEEP = 4'h8,
        OP_WDT_CLEAR = 4'h9,
        OP_INC_PTR = 4'hA
    } morf_op_t;

    typedef struct packed {
        morf_op_t op;
        logic [PC_W-1:0] arg;
    } morf_cmd_t;
    localparam int CMD_W = $bits(morf_cmd_t);

    // Same layout as the timer setup bits of the control page
    typedef struct packed {
        logic src_pin;
        logic edge_fall;
        logic presc_wdt;
        logic [2:0] ratio;
    } morf_tsetup_t;
    localparam int TS_W = $bits(morf_tsetup_t);
    localparam morf_tsetup_t TSETUP_RST = 6'h00;
endpackage

// ---- rtl/morf_top.sv ----
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module morf_top #(
    parameter int STACK_DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [morf_pkg::ADDR_W-1:0] paddr,
    input wire logic [morf_pkg::DATA_W-1:0] pwdata,
    output logic [morf_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins, asynchronous
    input wire logic timer_pin,
    input wire logic ext_irq_pin_n,
    input wire logic [morf_pkg::PORT_A_W-1:0] port_a_pin,
    input wire logic [morf_pkg::BYTE_W-1:0] port_b_pin,
    // Watchdog expiry from on-chip logic
    input wire logic wdt_timeout,
    // Outputs
    output logic [morf_pkg::PC_W-1:0] prog_addr,
    output logic [morf_pkg::PORT_A_W-1:0] port_a_out,
    output logic [morf_pkg::BYTE_W-1:0] port_b_out
);
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int CNT_W = $clog2(STACK_DEPTH + 1);
    localparam logic [SP_W-1:0] SP_LAST = SP_W'(STACK_DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(STACK_DEPTH);

    if (STACK_DEPTH < 2 || STACK_DEPTH > 16)
    begin : g_depth_chk
        $error("STACK_DEPTH must be 2 to 16");
    end

    logic pready_q, pslverr_q;
    logic [morf_pkg::DATA_W-1:0] prdata_q;
    logic [morf_pkg::PC_W-1:0] pc_q;
    logic [morf_pkg::PC_W-1:0] stk_q [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [CNT_W-1:0] cnt_q;
    logic [morf_pkg::BYTE_W-1:0] timer_q, presc_q, st_q, acc_q;
    logic [morf_pkg::PTR_W-1:0] ptr_q;
    logic [morf_pkg::PORT_A_W-1:0] port_a_q;
    logic [morf_pkg::BYTE_W-1:0] port_b_q;
    logic [morf_pkg::IRQ_W-1:0] flags_q, mask_q;
    morf_pkg::morf_tsetup_t tsetup_q;
    logic [morf_pkg::BUSY_W-1:0] busy_q;
    logic [morf_pkg::BUSY_W-1:0] icyc_q;
    logic [morf_pkg::BYTE_W-1:0] gp_q [morf_pkg::GP_COUNT];

    // Synchronisers; third stage only for edge detection
    logic [1:0] tpin_s, ext_s;
    logic tpin_d, ext_d;
    logic [morf_pkg::PORT_A_W-1:0] pa_s1, pa_s2;
    logic [morf_pkg::BYTE_W-1:0] pb_s1, pb_s2, pb_d;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tpin_s <= '0;
            ext_s <= 2'h3;
            tpin_d <= 1'b0;
            ext_d <= 1'b1;
            pa_s1 <= '0;
            pa_s2 <= '0;
            pb_s1 <= '0;
            pb_s2 <= '0;
            pb_d <= '0;
        end
        else
        begin
            tpin_s <= {tpin_s[0], timer_pin};
            ext_s <= {ext_s[0], ext_irq_pin_n};
            tpin_d <= tpin_s[1];
            ext_d <= ext_s[1];
            pa_s1 <= port_a_pin;
            pa_s2 <= pa_s1;
            pb_s1 <= port_b_pin;
            pb_s2 <= pb_s1;
            pb_d <= pb_s2;
        end
    end

    // Pin edges ignored until the synchronisers hold real pin levels
    logic [1:0] warm_q;
    logic warm;
    assign warm = &warm_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            warm_q <= '0;
        else if (!warm)
            warm_q <= warm_q + 1'b1;
    end

    // Bus decode
    logic [morf_pkg::IDX_W-1:0] idx, eff_idx;
    logic mapped, respond, done, wr;
    morf_pkg::morf_cmd_t cmd;
    logic [morf_pkg::BYTE_W-1:0] wbyte;

    assign idx = paddr[morf_pkg::IDX_LSB +: morf_pkg::IDX_W];
    assign eff_idx = (idx == morf_pkg::IDX_INDIRECT) ? morf_pkg::IDX_W'(ptr_q) : idx;
    assign mapped = (paddr[morf_pkg::IDX_LSB-1:0] == '0)
        && (paddr[morf_pkg::ADDR_W-1:morf_pkg::IDX_LSB+morf_pkg::IDX_W] == '0)
        && (idx <= morf_pkg::IDX_CORE_STAT);
    // Wait states: no answer while an instruction is still running
    assign respond = psel && penable && !pready_q && (busy_q == '0);
    assign done = psel && penable && pready_q;
    assign wr = done && pwrite && mapped;
    assign cmd = morf_pkg::morf_cmd_t'(pwdata[morf_pkg::CMD_W-1:0]);
    assign wbyte = pwdata[morf_pkg::BYTE_W-1:0];

    logic exec, wr_timer, wr_pc, wr_status, wr_ptr, wr_flags, pc_change;
    assign exec = wr && (eff_idx == morf_pkg::IDX_CORE_CMD);
    assign wr_timer = wr && (eff_idx == morf_pkg::IDX_TIMER);
    assign wr_pc = wr && (eff_idx == morf_pkg::IDX_PC);
    assign wr_status = wr && (eff_idx == morf_pkg::IDX_STATUS);
    assign wr_ptr = wr && (eff_idx == morf_pkg::IDX_RAMPTR);
    assign wr_flags = wr && (eff_idx == morf_pkg::IDX_IRQ_FLAGS);
    assign pc_change = wr_pc || (exec && (cmd.op inside {morf_pkg::OP_JUMP, morf_pkg::OP_CALL,
        morf_pkg::OP_RET, morf_pkg::OP_RETURN_WITH_LITERAL, morf_pkg::OP_RETURN_FROM_INTERRUPT, morf_pkg::OP_ADD_PC,
        morf_pkg::OP_MOV_PC}));

    // Stack top and add result
    logic [SP_W-1:0] sp_prev;
    logic [morf_pkg::PC_W-1:0] stack_top;
    logic [morf_pkg::BYTE_W:0] add_sum;
    assign sp_prev = (sp_q == '0) ? SP_LAST : sp_q - 1'b1;
    assign stack_top = stk_q[sp_prev];
    assign add_sum = {1'b0, pc_q[morf_pkg::BYTE_W-1:0]} + {1'b0, cmd.arg[morf_pkg::BYTE_W-1:0]};

    // Read mux
    logic [morf_pkg::DATA_W-1:0] rd_val;
    always_comb
    begin
        rd_val = '0;
        case (eff_idx)
            morf_pkg::IDX_INDIRECT: rd_val = '0;
            morf_pkg::IDX_TIMER: rd_val = morf_pkg::DATA_W'(timer_q);
            morf_pkg::IDX_PC: rd_val = morf_pkg::DATA_W'(pc_q);
            morf_pkg::IDX_STATUS: rd_val = morf_pkg::DATA_W'(st_q);
            morf_pkg::IDX_RAMPTR: rd_val = morf_pkg::DATA_W'({morf_pkg::PTR_FIXED_ONES, ptr_q});
            morf_pkg::IDX_PORT_A: rd_val = morf_pkg::DATA_W'(pa_s2);
            morf_pkg::IDX_PORT_B: rd_val = morf_pkg::DATA_W'(pb_s2);
            morf_pkg::IDX_IRQ_FLAGS: rd_val = morf_pkg::DATA_W'(flags_q & mask_q);
            morf_pkg::IDX_TSETUP: rd_val = morf_pkg::DATA_W'(tsetup_q);
            morf_pkg::IDX_IRQ_MASK: rd_val = morf_pkg::DATA_W'(mask_q);
            morf_pkg::IDX_CORE_STAT: rd_val = morf_pkg::DATA_W'({acc_q, cnt_q});
            default:
            begin
                if (eff_idx >= morf_pkg::IDX_GP_FIRST && eff_idx <= morf_pkg::IDX_GP_LAST)
                    rd_val = morf_pkg::DATA_W'(gp_q[6'(eff_idx - morf_pkg::IDX_GP_FIRST)]);
            end
        endcase
    end

    // APB answer
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else
        begin
            pready_q <= respond;
            pslverr_q <= respond && !mapped;
            if (respond)
                prdata_q <= (mapped && !pwrite) ? rd_val : '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            busy_q <= '0;
        else if (exec || wr_pc)
            busy_q <= pc_change ? morf_pkg::ICYCLE_CLKS << 1 : morf_pkg::ICYCLE_CLKS;
        else if (busy_q != '0)
            busy_q <= busy_q - 1'b1;
    end

    // Instruction cycle clock
    logic icyc_tick;
    assign icyc_tick = (icyc_q == morf_pkg::ICYCLE_CLKS - 1'b1);
    always_ff @(posedge core_clk)
    begin
        if (rst || icyc_tick)
            icyc_q <= '0;
        else
            icyc_q <= icyc_q + 1'b1;
    end

    // Timer source and prescaler
    logic pin_edge, src_evt, presc_hit, timer_inc, timer_ovf;
    logic [morf_pkg::BYTE_W-1:0] ratio_mask;
    assign pin_edge = warm
        && (tsetup_q.edge_fall ? (tpin_d && !tpin_s[1]) : (!tpin_d && tpin_s[1]));
    assign src_evt = tsetup_q.src_pin ? pin_edge : icyc_tick;
    assign ratio_mask = morf_pkg::BYTE_W'((16'h0002 << tsetup_q.ratio) - 16'h0001);
    assign presc_hit = (presc_q & ratio_mask) == ratio_mask;
    // prescaler routed when assign bit is zero
    assign timer_inc = src_evt && (tsetup_q.presc_wdt || presc_hit);
    assign timer_ovf = timer_inc && !wr_timer && (timer_q == morf_pkg::TIMER_MAX);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            presc_q <= '0;
        else if (wr_timer)
            presc_q <= '0;
        else if (src_evt && !tsetup_q.presc_wdt)
            presc_q <= presc_q + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            timer_q <= '0;
        else if (wr_timer)
            timer_q <= wbyte;
        else if (timer_inc)
            timer_q <= timer_q + 1'b1;
    end

    // Control page copies
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tsetup_q <= morf_pkg::TSETUP_RST;
            mask_q <= morf_pkg::IRQ_MASK_RST;
        end
        else
        begin
            if (wr && eff_idx == morf_pkg::IDX_TSETUP)
                tsetup_q <= morf_pkg::morf_tsetup_t'(pwdata[morf_pkg::TS_W-1:0]);
            if (wr && eff_idx == morf_pkg::IDX_IRQ_MASK)
                mask_q <= pwdata[morf_pkg::IRQ_W-1:0];
        end
    end

    // Program counter
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pc_q <= morf_pkg::PC_RST;
        else if (wr_pc)
            pc_q <= {2'b00, wbyte};
        else if (exec)
        begin
            unique case (cmd.op)
                morf_pkg::OP_JUMP: pc_q <= cmd.arg;
                morf_pkg::OP_CALL: pc_q <= cmd.arg;
                morf_pkg::OP_RET, morf_pkg::OP_RETURN_WITH_LITERAL, morf_pkg::OP_RETURN_FROM_INTERRUPT: pc_q <= stack_top;
                morf_pkg::OP_ADD_PC: pc_q <= {2'b00, add_sum[morf_pkg::BYTE_W-1:0]};
                morf_pkg::OP_MOV_PC: pc_q <= {2'b00, cmd.arg[morf_pkg::BYTE_W-1:0]};
                default: pc_q <= pc_q + 1'b1;
            endcase
        end
    end

    // 10-bit stack, oldest overwritten when full
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sp_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stk_q[i] <= '0;
        end
        else if (exec && cmd.op == morf_pkg::OP_CALL)
        begin
            stk_q[sp_q] <= pc_q + 1'b1;
            sp_q <= (sp_q == SP_LAST) ? '0 : sp_q + 1'b1;
            if (cnt_q != CNT_FULL)
                cnt_q <= cnt_q + 1'b1;
        end
        else if (exec && cmd.op inside {morf_pkg::OP_RET, morf_pkg::OP_RETURN_WITH_LITERAL, morf_pkg::OP_RETURN_FROM_INTERRUPT})
        begin
            sp_q <= sp_prev;
            if (cnt_q != '0)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // Literal returned by return_with_literal
    always_ff @(posedge core_clk)
    begin
        if (rst)
            acc_q <= '0;
        else if (exec && cmd.op == morf_pkg::OP_RETURN_WITH_LITERAL)
            acc_q <= cmd.arg[morf_pkg::BYTE_W-1:0];
    end

    // RAM pointer
    logic [morf_pkg::PTR_W-1:0] ptr_new;
    logic ptr_load;
    assign ptr_load = wr_ptr || (exec && cmd.op == morf_pkg::OP_INC_PTR);
    assign ptr_new = wr_ptr ? wbyte[morf_pkg::PTR_W-1:0] : ptr_q + 1'b1;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            ptr_q <= '0;
        else if (ptr_load)
            ptr_q <= ptr_new;
    end

    // Status flags
    always_ff @(posedge core_clk)
    begin
        if (rst)
            st_q <= morf_pkg::ST_RST;
        else
        begin
            // spare bits plus carry, half carry and zero flags writable
            if (wr_status)
                st_q <= (wbyte & morf_pkg::ST_SW_MASK) | (st_q & ~morf_pkg::ST_SW_MASK);
            // zero and carry from add result
            if (exec && cmd.op == morf_pkg::OP_ADD_PC)
            begin
                st_q[morf_pkg::ST_C] <= add_sum[morf_pkg::BYTE_W];
                st_q[morf_pkg::ST_Z] <= (add_sum[morf_pkg::BYTE_W-1:0] == '0);
            end
            if (ptr_load && ptr_new == morf_pkg::PTR_TOP)
                st_q[morf_pkg::ST_Z] <= 1'b1;
            if (exec && cmd.op == morf_pkg::OP_SLEEP)
                st_q[morf_pkg::ST_PD] <= 1'b0;
            else if (exec && cmd.op == morf_pkg::OP_WDT_CLEAR)
                st_q[morf_pkg::ST_PD] <= 1'b1;
            // time-out flag; set by instruction wins over expiry
            if (exec && cmd.op inside {morf_pkg::OP_SLEEP, morf_pkg::OP_WDT_CLEAR})
                st_q[morf_pkg::ST_TO] <= 1'b1;
            else if (wdt_timeout)
                st_q[morf_pkg::ST_TO] <= 1'b0;
        end
    end

    // port output latches, port A four bits
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            port_a_q <= '0;
            port_b_q <= '0;
        end
        else
        begin
            if (wr && eff_idx == morf_pkg::IDX_PORT_A)
                port_a_q <= wbyte[morf_pkg::PORT_A_W-1:0];
            if (wr && eff_idx == morf_pkg::IDX_PORT_B)
                port_b_q <= wbyte;
        end
    end

    logic [morf_pkg::IRQ_W-1:0] irq_set;
    assign irq_set[morf_pkg::IRQ_TIMER] = timer_ovf;
    assign irq_set[morf_pkg::IRQ_PORT] = warm && (pb_s2 != pb_d);
    assign irq_set[morf_pkg::IRQ_EXT] = warm && ext_d && !ext_s[1];
    always_ff @(posedge core_clk)
    begin
        if (rst)
            flags_q <= '0;
        // write only clears; new events win
        else if (wr_flags)
            flags_q <= (flags_q & pwdata[morf_pkg::IRQ_W-1:0]) | irq_set;
        else
            flags_q <= flags_q | irq_set;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < morf_pkg::GP_COUNT; i++)
                gp_q[i] <= '0;
        end
        else if (wr && eff_idx >= morf_pkg::IDX_GP_FIRST && eff_idx <= morf_pkg::IDX_GP_LAST)
            gp_q[6'(eff_idx - morf_pkg::IDX_GP_FIRST)] <= wbyte;
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prog_addr = pc_q;
    assign port_a_out = port_a_q;
    assign port_b_out = port_b_q;

    // Checks
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_PC_RESET: assert property (disable iff (1'b0) rst |=> prog_addr == '0)
        else $error("counter not zero after reset");
    AST_JUMP_LOAD: assert property (exec && cmd.op == morf_pkg::OP_JUMP
        |=> prog_addr == $past(cmd.arg))
        else $error("jump target not loaded");
    AST_CALL_PUSH: assert property (exec && cmd.op == morf_pkg::OP_CALL
        |=> stack_top == $past(pc_q) + 1'b1 && prog_addr == $past(cmd.arg))
        else $error("call did not push next address");
    AST_RET_POP: assert property (exec && cmd.op inside {morf_pkg::OP_RET,
        morf_pkg::OP_RETURN_WITH_LITERAL, morf_pkg::OP_RETURN_FROM_INTERRUPT} |=> prog_addr == $past(stack_top))
        else $error("return did not reload from stack");
    AST_HIGH_CLEAR: assert property (wr_pc || (exec && cmd.op inside
        {morf_pkg::OP_ADD_PC, morf_pkg::OP_MOV_PC}) |=> prog_addr[9:8] == 2'b00)
        else $error("computed jump left high bits");
    AST_BUSY_LEN: assert property ((exec || wr_pc)
        |=> busy_q == ($past(pc_change) ? 4'h4 : 4'h2) ##1 busy_q != '0)
        else $error("instruction duration wrong");
    AST_PRESC_CLEAR: assert property (wr_timer |=> presc_q == '0)
        else $error("prescaler not cleared by timer write");
    AST_NO_SW_SET: assert property (wr_flags && irq_set == '0
        |=> (flags_q & ~$past(flags_q)) == '0)
        else $error("software set an interrupt flag");
    AST_FLAG_READ: assert property (respond && !pwrite && mapped
        && eff_idx == morf_pkg::IDX_IRQ_FLAGS
        |=> prdata[2:0] == $past(flags_q & mask_q) && pready)
        else $error("flag read not masked");
    AST_PTR_ONES: assert property (respond && !pwrite && mapped
        && eff_idx == morf_pkg::IDX_RAMPTR |=> prdata[7:6] == 2'b11)
        else $error("pointer top bits not one");
    AST_SLEEP_FLAGS: assert property (exec && cmd.op == morf_pkg::OP_SLEEP
        |=> !st_q[morf_pkg::ST_PD] && st_q[morf_pkg::ST_TO])
        else $error("sleep flags wrong");

    COV_CALL_RET: cover property (exec && cmd.op == morf_pkg::OP_CALL ##[1:40]
        exec && cmd.op == morf_pkg::OP_RET);
    COV_TIMER_OVF: cover property (timer_ovf);
    COV_EXT_IRQ: cover property (irq_set[morf_pkg::IRQ_EXT]);
    COV_INDIRECT_WR: cover property (wr && idx == morf_pkg::IDX_INDIRECT && ptr_q != '0);
endmodule

// ---- test/mcu_operational_register_file_tb.sv ----
`timescale 1ns/1ps
module mcu_operational_register_file_tb;
    logic core_clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic timer_pin = 0;
    logic ext_irq_pin_n = 1;
    logic wdt_timeout = 0;
    logic [3:0] port_a_pin = 4'h0;
    logic [7:0] port_b_pin = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [3:0] port_a_out;
    logic [7:0] port_b_out, gv;
    logic [9:0] prog_addr;
    // Expectation notes: check flag, error flag, data
    logic [33:0] exq[$];
    logic [33:0] e;
    int err_count = 0;
    int checks = 0;
    int i;
    morf_top uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_pin(timer_pin), .ext_irq_pin_n(ext_irq_pin_n),
        .port_a_pin(port_a_pin), .port_b_pin(port_b_pin), .wdt_timeout(wdt_timeout),
        .prog_addr(prog_addr), .port_a_out(port_a_out), .port_b_out(port_b_out));
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic finish_test;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(string n, logic [31:0] x, logic [31:0] s);
        checks++;
        if (s !== x)
        begin
            $display("wrong value %s expected %h seen %h", n, x, s);
            err_count++;
        end
    endtask
    // Request held until pready is sampled high
    task automatic apb(logic wr, logic [7:0] ix, logic [31:0] d, logic c, logic er);
        int n;
        exq.push_back({c, er, d});
        @(posedge core_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= {2'h0, ix, 2'h0};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        psel <= 0;
        penable <= 0;
        if (n >= 100)
        begin
            err_count++;
            finish_test();
        end
    endtask
    task automatic rd(logic [7:0] ix, logic [31:0] d);
        apb(1'b0, ix, d, 1'b1, 1'b0);
    endtask
    task automatic wr(logic [7:0] ix, logic [31:0] d);
        apb(1'b1, ix, d, 1'b0, 1'b0);
    endtask
    // Reserved read waits out the busy time
    task automatic cmd(logic [3:0] op, logic [9:0] arg);
        wr(8'h40, {18'h0, op, arg});
        rd(8'h07, 32'h0);
    endtask
    task automatic pc(logic [9:0] x);
        cmp("prog_addr", {22'h0, x}, {22'h0, prog_addr});
    endtask
    task automatic tpulse(int n);
        repeat (n)
        begin
            timer_pin <= 1;
            repeat (4) @(posedge core_clk);
            timer_pin <= 0;
            repeat (4) @(posedge core_clk);
        end
    endtask
    always @(posedge core_clk)
    begin
        if (pready === 1'b1)
        begin
            e = exq.pop_front();
            if (e[33])
                cmp("prdata", e[31:0], prdata);
            cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        end
    end
    initial
    begin
        void'($urandom(69));
        repeat (3) @(posedge core_clk);
        rst <= 0;
        pc(10'h000);
        rd(8'h03, 32'h18);
        rd(8'h04, 32'hC0);
        wr(8'h41, 32'h20);
        wr(8'h03, 32'hE0);
        rd(8'h03, 32'hF8);
        cmd(4'h8, 10'h0);
        rd(8'h03, 32'hF0);
        wdt_timeout <= 1;
        @(posedge core_clk);
        wdt_timeout <= 0;
        rd(8'h03, 32'hE0);
        cmd(4'h9, 10'h0);
        rd(8'h03, 32'hF8);
        wr(8'h04, 32'h3F);
        rd(8'h04, 32'hFF);
        rd(8'h03, 32'hFC);
        cmd(4'hA, 10'h0);
        rd(8'h04, 32'hC0);
        gv = 8'($urandom);
        wr(8'h3F, {24'h0, gv});
        wr(8'h10, {24'h0, ~gv});
        rd(8'h3F, {24'h0, gv});
        wr(8'h04, 32'h10);
        rd(8'h00, {24'h0, ~gv});
        wr(8'h00, {24'h0, gv});
        rd(8'h10, {24'h0, gv});
        wr(8'h05, 32'hFF);
        wr(8'h06, {24'h0, gv});
        // Latches change at the edge that ends the write
        @(posedge core_clk);
        cmp("port_a_out", 32'hF, {28'h0, port_a_out});
        cmp("port_b_out", {24'h0, gv}, {24'h0, port_b_out});
        for (i = 3; i < 6; i++)
        begin
            cmd(4'h1, 10'h2A5);
            pc(10'h2A5);
            cmd(4'h2, 10'h155);
            pc(10'h155);
            cmd(4'(i), 10'h0);
            pc(10'h2A6);
        end
        wr(8'h02, 32'h1AB);
        rd(8'h07, 32'h0);
        pc(10'h0AB);
        cmd(4'h7, 10'h3CD);
        pc(10'h0CD);
        cmd(4'h6, 10'h040);
        pc(10'h00D);
        rd(8'h03, 32'hF9);
        // Prescaler left odd, so a missed clear shifts the tick
        wr(8'h01, 32'h00);
        tpulse(1);
        wr(8'h01, 32'hFE);
        tpulse(3);
        rd(8'h01, 32'hFF);
        tpulse(1);
        rd(8'h01, 32'h00);
        wr(8'h42, 32'h7);
        port_b_pin <= 8'h5A;
        ext_irq_pin_n <= 0;
        repeat (6) @(posedge core_clk);
        rd(8'h0F, 32'h7);
        wr(8'h42, 32'h0);
        rd(8'h0F, 32'h0);
        wr(8'h42, 32'h5);
        wr(8'h0F, 32'hFF);
        rd(8'h0F, 32'h5);
        wr(8'h0F, 32'h0);
        wr(8'h0F, 32'hFF);
        wr(8'h42, 32'h7);
        rd(8'h0F, 32'h0);
        apb(1'b0, 8'h44, 32'h0, 1'b1, 1'b1);
        finish_test();
    end
endmodule
